//--- src/psrc_defines.vh
`ifndef PSRC_DEFINES_VH
`define PSRC_DEFINES_VH

// ---------------------------------------------------------------
// command codes on the management bus
// ---------------------------------------------------------------
`define PSRC_CMD_REDUCED 8'haa
`define PSRC_CMD_SHED 8'hab
`define PSRC_CMD_REPORT 8'had
`define PSRC_CMD_CAPTURE 8'he0

// ---------------------------------------------------------------
// writable bits and reset values
// ---------------------------------------------------------------
`define PSRC_REDUCED_MASK 16'h00ff
`define PSRC_SHED_MASK 16'hffff
`define PSRC_REPORT_MASK 16'h0fff
`define PSRC_REDUCED_RST 16'h0000
`define PSRC_SHED_RST 16'h0000
`define PSRC_REPORT_RST 16'h0000

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PSRC_WARM_HI 7
`define PSRC_WARM_LO 4
`define PSRC_COLD_HI 3
`define PSRC_COLD_LO 0
`define PSRC_RESUME_HI 15
`define PSRC_RESUME_LO 10
`define PSRC_UV_BIT 9
`define PSRC_PRD_BIT 8
`define PSRC_OC_BIT 7
`define PSRC_SPACE_HI 6
`define PSRC_SPACE_LO 1
`define PSRC_SEQ_BIT 0
`define PSRC_MODE_HI 11
`define PSRC_MODE_LO 10
`define PSRC_SPAN_HI 9
`define PSRC_SPAN_LO 0

// ---------------------------------------------------------------
// reporting modes and misc values
// ---------------------------------------------------------------
`define PSRC_MODE_AVG 2'b00
`define PSRC_MODE_RT 2'b01
`define PSRC_MODE_LATCH 2'b10
`define PSRC_ONE_PHASE 4'h1
`define PSRC_SPAN_MIN 10'h001

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PSRC_CLK_MHZ 16'd250
`define PSRC_DROP_UNIT_US 16'd1
`define PSRC_RESUME_UNIT_US 16'd20
`define PSRC_SPAN_UNIT_US 16'd100

`endif

//--- src/psrc_tick.v
// unit tick divider, restartable
module psrc_tick #(
  parameter [15:0] DIV = 16'd250
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_clear,
  output reg o_tick
);
  localparam [15:0] LAST = DIV - 16'd1;
  reg [15:0] cnt_reg;

  // count clock cycles, pulse once per unit
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 16'h0000;
      o_tick <= 1'b0;
    end else if (i_clear) begin
      cnt_reg <= 16'h0000;
      o_tick <= 1'b0;
    end else if (cnt_reg >= LAST) begin
      cnt_reg <= 16'h0000;
      o_tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      o_tick <= 1'b0;
    end
  end
endmodule // psrc_tick

//--- src/psrc_avg.v
`include "psrc_defines.vh"

// windowed average of one sample per unit tick
module psrc_avg (
  input wire i_clock,
  input wire i_rst,
  input wire i_restart,
  input wire i_run,
  input wire i_tick,
  input wire [9:0] i_span,
  input wire [15:0] i_sample,
  output reg [15:0] o_avg,
  output reg o_done
);
  reg [25:0] sum_reg;
  reg [9:0] units_reg;
  wire [9:0] span_eff;
  wire [25:0] total;
  wire [25:0] quot;

  // zero span behaves as one unit
  assign span_eff = (i_span == 10'h000) ? `PSRC_SPAN_MIN : i_span;
  assign total = sum_reg + {10'h000, i_sample};
  assign quot = total / {16'h0000, span_eff};

  // accumulate, divide and publish at window end
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sum_reg <= 26'h0000000;
      units_reg <= 10'h000;
      o_avg <= 16'h0000;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_restart) begin
        sum_reg <= 26'h0000000;
        units_reg <= 10'h000;
      end else if (i_run && i_tick) begin
        if (units_reg + 10'h001 >= span_eff) begin
          o_avg <= quot[15:0];
          o_done <= 1'b1;
          sum_reg <= 26'h0000000;
          units_reg <= 10'h000;
        end else begin
          sum_reg <= total;
          units_reg <= units_reg + 10'h001;
        end
      end
    end
  end
endmodule // psrc_avg

//--- src/psrc_top.v
`include "psrc_defines.vh"

module psrc_top #(
  parameter [15:0] RESUME_UNIT_CYC = `PSRC_RESUME_UNIT_US * `PSRC_CLK_MHZ,
  parameter [15:0] SPAN_UNIT_CYC = `PSRC_SPAN_UNIT_US * `PSRC_CLK_MHZ
) (
  input wire i_clock,
  input wire i_rst,
  input wire [7:0] i_bus_cmd,
  input wire [15:0] i_bus_wdata,
  input wire i_bus_wr_word,
  input wire i_bus_rd_word,
  input wire i_bus_send_byte,
  output reg [15:0] o_bus_rdata,
  output reg o_bus_rvalid,
  output reg o_bus_nack,
  input wire i_boot_start,
  input wire i_power_state_low_input_n,
  input wire i_aps_enable,
  input wire [3:0] i_full_phases,
  input wire [3:0] i_shed_target,
  input wire i_fb_below_ref_25mv,
  input wire i_short_interval,
  input wire i_valley_limit_ph1,
  input wire [15:0] i_iout_sample,
  output reg [3:0] o_phase_count,
  output reg o_forced_full,
  output reg o_shedding,
  output reg o_warm_boot,
  output reg [15:0] o_iout_report,
  output reg o_capture_busy,
  output reg o_capture_done,
  output reg [1:0] o_mode_vin,
  output reg [1:0] o_mode_vout,
  output reg [1:0] o_mode_iout,
  output reg [1:0] o_mode_temp,
  output reg [1:0] o_mode_eff,
  output reg [1:0] o_mode_pout,
  output reg [1:0] o_mode_pin
);

  // -------------------------------------------------------------
  // constants
  // -------------------------------------------------------------
  localparam [15:0] DROP_UNIT_CYC = `PSRC_DROP_UNIT_US * `PSRC_CLK_MHZ;
  localparam [1:0] ST_FULL = 2'd0;
  localparam [1:0] ST_SHED = 2'd1;
  localparam [1:0] ST_FORCED = 2'd2;

  // -------------------------------------------------------------
  // functions
  // -------------------------------------------------------------
  // collapse 1x to latch, then drop unsupported modes to average
  function [1:0] eff_mode;
    input [1:0] sel;
    input has_rt;
    input has_latch;
    reg [1:0] base;
    begin
      base = sel[1] ? `PSRC_MODE_LATCH : sel;
      if (base == `PSRC_MODE_RT && !has_rt)
        eff_mode = `PSRC_MODE_AVG;
      else if (base == `PSRC_MODE_LATCH && !has_latch)
        eff_mode = `PSRC_MODE_AVG;
      else
        eff_mode = base;
    end
  endfunction

  // -------------------------------------------------------------
  // registers and state
  // -------------------------------------------------------------
  reg [15:0] reduced_phase_count_reg;
  reg [15:0] auto_shed_control_reg;
  reg [15:0] telemetry_report_control_reg;
  reg boot_seen_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] count_next;
  reg [5:0] delay_reg;
  reg [5:0] delay_next;
  reg [5:0] gap_reg;
  reg [5:0] gap_next;
  reg capture_armed_reg;
  reg forced_entry;
  reg drop_entry;

  wire cmd_reduced;
  wire cmd_shed;
  wire cmd_report;
  wire cmd_known;
  wire capture_cmd;
  wire [3:0] warm_phases;
  wire [3:0] cold_phases;
  wire [5:0] resume_delay;
  wire [5:0] drop_spacing;
  wire uv_exit_en;
  wire short_interval_exit_enable;
  wire valley_limit_exit_enable;
  wire seq_drop;
  wire [1:0] report_sel;
  wire [9:0] span;
  wire latch_mode;
  wire exit_trigger;
  wire psi_low;
  wire drop_tick;
  wire resume_tick;
  wire span_tick;
  wire [15:0] avg_value;
  wire avg_done;
  wire avg_run;
  wire [1:0] iout_mode;

  // -------------------------------------------------------------
  // field decode
  // -------------------------------------------------------------
  assign cmd_reduced = (i_bus_cmd == `PSRC_CMD_REDUCED);
  assign cmd_shed = (i_bus_cmd == `PSRC_CMD_SHED);
  assign cmd_report = (i_bus_cmd == `PSRC_CMD_REPORT);
  assign cmd_known = cmd_reduced | cmd_shed | cmd_report;
  assign capture_cmd = i_bus_send_byte && (i_bus_cmd == `PSRC_CMD_CAPTURE);
  assign warm_phases = reduced_phase_count_reg[`PSRC_WARM_HI:`PSRC_WARM_LO];
  assign cold_phases = reduced_phase_count_reg[`PSRC_COLD_HI:`PSRC_COLD_LO];
  assign resume_delay = auto_shed_control_reg[`PSRC_RESUME_HI:`PSRC_RESUME_LO];
  assign drop_spacing = auto_shed_control_reg[`PSRC_SPACE_HI:`PSRC_SPACE_LO];
  assign uv_exit_en = auto_shed_control_reg[`PSRC_UV_BIT];
  assign short_interval_exit_enable = auto_shed_control_reg[`PSRC_PRD_BIT];
  assign valley_limit_exit_enable = auto_shed_control_reg[`PSRC_OC_BIT];
  assign seq_drop = auto_shed_control_reg[`PSRC_SEQ_BIT];
  assign report_sel = telemetry_report_control_reg[`PSRC_MODE_HI:`PSRC_MODE_LO];
  assign span = telemetry_report_control_reg[`PSRC_SPAN_HI:`PSRC_SPAN_LO];
  assign latch_mode = report_sel[1];
  assign psi_low = ~i_power_state_low_input_n;

  // any enabled exit condition while shedding
  assign exit_trigger = (uv_exit_en & i_fb_below_ref_25mv) |
    (short_interval_exit_enable & i_short_interval) |
    (valley_limit_exit_enable & i_valley_limit_ph1 &
     (o_phase_count == `PSRC_ONE_PHASE));

  // -------------------------------------------------------------
  // unit ticks
  // -------------------------------------------------------------
  // 1 us tick, restarted at each drop so spacing is exact
  psrc_tick #(.DIV(DROP_UNIT_CYC)) u_drop_tick (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clear(drop_entry),
    .o_tick(drop_tick)
  );

  // 20 us tick, restarted on entry to forced full running
  psrc_tick #(.DIV(RESUME_UNIT_CYC)) u_resume_tick (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clear(forced_entry),
    .o_tick(resume_tick)
  );

  // 100 us tick for the telemetry window
  psrc_tick #(.DIV(SPAN_UNIT_CYC)) u_span_tick (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clear(capture_cmd),
    .o_tick(span_tick)
  );

  // -------------------------------------------------------------
  // register writes and reads
  // -------------------------------------------------------------
  // word write lands at transaction end, reserved bits masked
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      reduced_phase_count_reg <= `PSRC_REDUCED_RST;
      auto_shed_control_reg <= `PSRC_SHED_RST;
      telemetry_report_control_reg <= `PSRC_REPORT_RST;
    end else if (i_bus_wr_word) begin
      if (cmd_reduced)
        reduced_phase_count_reg <= i_bus_wdata & `PSRC_REDUCED_MASK;
      if (cmd_shed)
        auto_shed_control_reg <= i_bus_wdata & `PSRC_SHED_MASK;
      if (cmd_report)
        telemetry_report_control_reg <= i_bus_wdata & `PSRC_REPORT_MASK;
    end
  end

  // read word answer and refusal of unknown codes
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_bus_rdata <= 16'h0000;
      o_bus_rvalid <= 1'b0;
      o_bus_nack <= 1'b0;
    end else begin
      o_bus_rvalid <= i_bus_rd_word;
      o_bus_nack <= ((i_bus_rd_word | i_bus_wr_word) & ~cmd_known) |
        (i_bus_send_byte & ~capture_cmd);
      if (i_bus_rd_word) begin
        if (cmd_reduced)
          o_bus_rdata <= reduced_phase_count_reg & `PSRC_REDUCED_MASK;
        else if (cmd_shed)
          o_bus_rdata <= auto_shed_control_reg & `PSRC_SHED_MASK;
        else if (cmd_report)
          o_bus_rdata <= telemetry_report_control_reg & `PSRC_REPORT_MASK;
        else
          o_bus_rdata <= 16'h0000;
      end
    end
  end

  // -------------------------------------------------------------
  // boot classification
  // -------------------------------------------------------------
  // first boot after reset is cold, every later one warm
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      boot_seen_reg <= 1'b0;
      o_warm_boot <= 1'b0;
    end else if (i_boot_start) begin
      o_warm_boot <= boot_seen_reg;
      boot_seen_reg <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // phase shedding control
  // -------------------------------------------------------------
  // next state, phase count and counters
  always @* begin
    state_next = state_reg;
    count_next = o_phase_count;
    delay_next = delay_reg;
    gap_next = gap_reg;
    forced_entry = 1'b0;
    drop_entry = 1'b0;
    case (state_reg)
      ST_FULL: begin
        count_next = i_full_phases;
        if (i_aps_enable && i_shed_target < i_full_phases) begin
          state_next = ST_SHED;
          gap_next = 6'h00;
          drop_entry = 1'b1;
        end
      end
      ST_SHED: begin
        if (!i_aps_enable) begin
          state_next = ST_FULL;
          count_next = i_full_phases;
        end else if (exit_trigger) begin
          state_next = ST_FORCED;
          count_next = i_full_phases;
          delay_next = resume_delay;
          forced_entry = 1'b1;
        end else if (o_phase_count > i_shed_target) begin
          if (!seq_drop) begin
            count_next = i_shed_target;
          end else if (drop_tick) begin
            if (gap_reg + 6'h01 >= drop_spacing) begin
              count_next = o_phase_count - 4'h1;
              gap_next = 6'h00;
              drop_entry = 1'b1;
            end else begin
              gap_next = gap_reg + 6'h01;
            end
          end
        end else begin
          count_next = i_shed_target; // added phases come back at once
          gap_next = 6'h00;
        end
      end
      ST_FORCED: begin
        count_next = i_full_phases;
        if (delay_reg == 6'h00) begin
          state_next = i_aps_enable ? ST_SHED : ST_FULL;
          gap_next = 6'h00;
          drop_entry = 1'b1;
        end else if (resume_tick) begin
          delay_next = delay_reg - 6'h01;
        end
      end
      default: begin
        state_next = ST_FULL;
        count_next = i_full_phases;
      end
    endcase
    // low power state overrides shedding with the boot-dependent count
    if (psi_low)
      count_next = o_warm_boot ? warm_phases : cold_phases;
  end

  // state and phase count flops
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_FULL;
      delay_reg <= 6'h00;
      gap_reg <= 6'h00;
      o_phase_count <= 4'h0;
      o_forced_full <= 1'b0;
      o_shedding <= 1'b0;
    end else begin
      state_reg <= state_next;
      delay_reg <= delay_next;
      gap_reg <= gap_next;
      o_phase_count <= count_next;
      o_forced_full <= (state_next == ST_FORCED);
      o_shedding <= (state_next == ST_SHED);
    end
  end

  // -------------------------------------------------------------
  // telemetry reporting
  // -------------------------------------------------------------
  assign iout_mode = eff_mode(report_sel, 1'b1, 1'b1);
  // latched mode runs only while a capture is armed
  assign avg_run = latch_mode ? capture_armed_reg : 1'b1;

  // output current averager over the span window
  psrc_avg u_iout_avg (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_restart(capture_cmd | (i_bus_wr_word & cmd_report)),
    .i_run(avg_run),
    .i_tick(span_tick),
    .i_span(span),
    .i_sample(i_iout_sample),
    .o_avg(avg_value),
    .o_done(avg_done)
  );

  // capture arm: command sets, window end clears, set wins
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      capture_armed_reg <= 1'b0;
      o_capture_busy <= 1'b0;
      o_capture_done <= 1'b0;
    end else begin
      o_capture_done <= avg_done & latch_mode & capture_armed_reg;
      if (capture_cmd && latch_mode) begin
        capture_armed_reg <= 1'b1;
        o_capture_busy <= 1'b1;
      end else if (avg_done || !latch_mode) begin
        capture_armed_reg <= 1'b0;
        o_capture_busy <= 1'b0;
      end
    end
  end

  // per-readout effective modes and the current report
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_mode_vin <= `PSRC_MODE_AVG;
      o_mode_vout <= `PSRC_MODE_AVG;
      o_mode_iout <= `PSRC_MODE_AVG;
      o_mode_temp <= `PSRC_MODE_RT;
      o_mode_eff <= `PSRC_MODE_AVG;
      o_mode_pout <= `PSRC_MODE_AVG;
      o_mode_pin <= `PSRC_MODE_AVG;
      o_iout_report <= 16'h0000;
    end else begin
      o_mode_vin <= eff_mode(report_sel, 1'b1, 1'b0);
      o_mode_vout <= eff_mode(report_sel, 1'b1, 1'b0);
      o_mode_iout <= iout_mode;
      o_mode_temp <= `PSRC_MODE_RT;
      o_mode_eff <= eff_mode(report_sel, 1'b0, 1'b1);
      o_mode_pout <= eff_mode(report_sel, 1'b0, 1'b1);
      o_mode_pin <= eff_mode(report_sel, 1'b0, 1'b1);
      if (iout_mode == `PSRC_MODE_RT)
        o_iout_report <= i_iout_sample;
      else
        o_iout_report <= avg_value;
    end
  end

endmodule // psrc_top

//--- verif/psrc_host.sv
// management bus host, one strobe per word
module psrc_host (
  input wire logic i_clock,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  output logic [7:0] o_cmd,
  output logic [15:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  output logic o_sb
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_cmd = 8'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_sb = 1'b0;
  end

  // whole word written in one transaction
  task automatic wr_word(input logic [7:0] c, input logic [15:0] d);
    @(negedge i_clock);
    o_cmd = c;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clock);
    o_wr = 1'b0;
    o_wdata = ~d; // released data does not hold
  endtask

  // whole word read, bounded wait for valid
  task automatic rd_word(input logic [7:0] c, output logic [15:0] d);
    int n;
    @(negedge i_clock);
    o_cmd = c;
    o_rd = 1'b1;
    @(negedge i_clock);
    o_rd = 1'b0;
    n = 0;
    while (i_rvalid !== 1'b1 && n < 4) begin
      @(negedge i_clock);
      n++;
    end
    d = (i_rvalid === 1'b1) ? i_rdata : 16'hxxxx;
  endtask

  // send-byte command, e.g. begin averaged capture
  task automatic sb(input logic [7:0] c);
    @(negedge i_clock);
    o_cmd = c;
    o_sb = 1'b1;
    @(negedge i_clock);
    o_sb = 1'b0;
  endtask
endmodule // psrc_host

//--- verif/psrc_top_sva.sv
`include "psrc_defines.vh"

module psrc_top_sva (
  input wire i_clock,
  input wire i_rst,
  input wire [7:0] i_bus_cmd,
  input wire [15:0] i_bus_wdata,
  input wire i_bus_wr_word,
  input wire i_bus_rd_word,
  input wire i_bus_send_byte,
  input wire [15:0] o_bus_rdata,
  input wire o_bus_rvalid,
  input wire o_bus_nack,
  input wire i_boot_start,
  input wire i_fb_below_ref_25mv,
  input wire i_short_interval,
  input wire i_valley_limit_ph1,
  input wire i_aps_enable,
  input wire o_forced_full,
  input wire o_shedding,
  input wire o_warm_boot,
  input wire o_capture_done,
  input wire [1:0] o_mode_vin,
  input wire [1:0] o_mode_vout,
  input wire [1:0] o_mode_temp,
  input wire [1:0] o_mode_eff,
  input wire [1:0] o_mode_pout,
  input wire [1:0] o_mode_pin
);
  reg [15:0] shed_reg;
  wire bad_code = i_bus_cmd != `PSRC_CMD_REDUCED && i_bus_cmd != `PSRC_CMD_SHED
    && i_bus_cmd != `PSRC_CMD_REPORT;

  // shadow of the shedding control word
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      shed_reg <= 16'h0000;
    end else if (i_bus_wr_word && i_bus_cmd == `PSRC_CMD_SHED) begin
      shed_reg <= i_bus_wdata;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_read_answer: assert property (i_bus_rd_word |=> o_bus_rvalid)
    else $error("read not answered");
  a_nack_unknown: assert property ((i_bus_wr_word || i_bus_rd_word) && bad_code
    || i_bus_send_byte && i_bus_cmd != `PSRC_CMD_CAPTURE |=> o_bus_nack)
    else $error("unknown code not refused");
  a_reduced_upper: assert property (o_bus_rvalid && $past(i_bus_rd_word)
    && $past(i_bus_cmd) == `PSRC_CMD_REDUCED |-> o_bus_rdata[15:8] == 8'h00)
    else $error("reduced word upper bits set");
  a_report_upper: assert property (o_bus_rvalid && $past(i_bus_rd_word)
    && $past(i_bus_cmd) == `PSRC_CMD_REPORT |-> o_bus_rdata[15:12] == 4'h0)
    else $error("report word upper bits set");
  a_uv_exit: assert property (o_shedding && !o_forced_full &&
    i_aps_enable && shed_reg[`PSRC_UV_BIT] && i_fb_below_ref_25mv |=> o_forced_full)
    else $error("undervoltage exit missed");
  a_short_ignored: assert property (o_shedding && !o_forced_full &&
    shed_reg[9:7] == 3'b000 && i_short_interval |=> !o_forced_full)
    else $error("disabled trigger acted");
  a_temp_rt: assert property (o_mode_temp == `PSRC_MODE_RT)
    else $error("temperature not real time");
  a_volt_modes: assert property (o_mode_vin != `PSRC_MODE_LATCH
    && o_mode_vin == o_mode_vout) else $error("voltage mode wrong");
  a_power_modes: assert property (o_mode_eff != `PSRC_MODE_RT
    && o_mode_eff == o_mode_pout && o_mode_eff == o_mode_pin)
    else $error("power mode wrong");
  a_warm_cause: assert property ($rose(o_warm_boot) |-> $past(i_boot_start))
    else $error("warm boot without boot");
  a_done_pulse: assert property (o_capture_done |=> !o_capture_done)
    else $error("capture done not a pulse");

  c_nack: cover property (o_bus_nack);
  c_done: cover property (o_capture_done);
  c_forced: cover property ($rose(o_forced_full));
endmodule // psrc_top_sva

bind psrc_top psrc_top_sva u_sva (.i_clock(i_clock), .i_rst(i_rst),
  .i_bus_cmd(i_bus_cmd), .i_bus_wdata(i_bus_wdata), .i_bus_wr_word(i_bus_wr_word),
  .i_bus_rd_word(i_bus_rd_word), .i_bus_send_byte(i_bus_send_byte),
  .o_bus_rdata(o_bus_rdata), .o_bus_rvalid(o_bus_rvalid), .o_bus_nack(o_bus_nack),
  .i_boot_start(i_boot_start), .i_fb_below_ref_25mv(i_fb_below_ref_25mv),
  .i_short_interval(i_short_interval), .i_valley_limit_ph1(i_valley_limit_ph1),
  .i_aps_enable(i_aps_enable),
  .o_forced_full(o_forced_full), .o_shedding(o_shedding), .o_warm_boot(o_warm_boot),
  .o_capture_done(o_capture_done), .o_mode_vin(o_mode_vin), .o_mode_vout(o_mode_vout),
  .o_mode_temp(o_mode_temp), .o_mode_eff(o_mode_eff), .o_mode_pout(o_mode_pout),
  .o_mode_pin(o_mode_pin));

//--- verif/psrc_top_tb.sv
module psrc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] c; logic [15:0] d; logic [15:0] e; logic nk;} psrc_row_t;
  localparam psrc_row_t ROWS [6] = '{'{8'haa, 16'h1234, 16'h0034, 1'b0},
    '{8'haa, 16'hffff, 16'h00ff, 1'b0}, '{8'hab, 16'ha5c3, 16'ha5c3, 1'b0},
    '{8'had, 16'hffff, 16'h0fff, 1'b0}, '{8'had, 16'h1801, 16'h0801, 1'b0},
    '{8'h5a, 16'h5555, 16'h0000, 1'b1}};
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic boot = 1'b0, psi_n = 1'b1, automatic_phase_shedding = 1'b0, fb = 1'b0, shrt = 1'b0, vly = 1'b0;
  logic [3:0] target = 4'h2, pc;
  logic [15:0] sample = 16'h0100, rdata, rv, rep;
  logic [7:0] cmd;
  logic [15:0] wdata;
  logic wr, rd, sb, rvalid, nack, forced, shed, warm, busy, done;
  logic [1:0] mv, mvo, mi, mt, me, mpo, mpi;
  int mismatches = 0;
  int num_checks = 0;
  int nk = 0;
  int n0, n;

  always #2 i_clock = ~i_clock;
  // count refusals while the pulse stands, away from the launching edge
  always @(negedge i_clock) if (nack === 1'b1) nk++;

  psrc_top #(.RESUME_UNIT_CYC(16'd10), .SPAN_UNIT_CYC(16'd20)) DUT (
    .i_clock(i_clock), .i_rst(i_rst), .i_bus_cmd(cmd), .i_bus_wdata(wdata),
    .i_bus_wr_word(wr), .i_bus_rd_word(rd), .i_bus_send_byte(sb), .o_bus_rdata(rdata),
    .o_bus_rvalid(rvalid), .o_bus_nack(nack), .i_boot_start(boot),
    .i_power_state_low_input_n(psi_n), .i_aps_enable(automatic_phase_shedding), .i_full_phases(4'h6),
    .i_shed_target(target), .i_fb_below_ref_25mv(fb), .i_short_interval(shrt),
    .i_valley_limit_ph1(vly), .i_iout_sample(sample), .o_phase_count(pc),
    .o_forced_full(forced), .o_shedding(shed), .o_warm_boot(warm), .o_iout_report(rep),
    .o_capture_busy(busy), .o_capture_done(done), .o_mode_vin(mv), .o_mode_vout(mvo),
    .o_mode_iout(mi), .o_mode_temp(mt), .o_mode_eff(me), .o_mode_pout(mpo),
    .o_mode_pin(mpi));

  psrc_host host (.i_clock(i_clock), .i_rdata(rdata), .i_rvalid(rvalid), .o_cmd(cmd),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_sb(sb));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge i_clock);
  endtask

  // expected effective mode of one readout
  function automatic logic [1:0] em(input logic [1:0] m, input bit rt, input bit lt);
    if (m[1]) return lt ? 2'b10 : 2'b00;
    return (m[0] && rt) ? 2'b01 : 2'b00;
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    test_done();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(6);
    i_rst = 1'b0;
    foreach (ROWS[i]) begin
      n0 = nk;
      host.wr_word(ROWS[i].c, ROWS[i].d);
      host.rd_word(ROWS[i].c, rv);
      chk("readback", ROWS[i].e, rv);
      cyc(2);
      chk("nack", ROWS[i].nk ? 16'h0002 : 16'h0000, 16'(nk - n0));
    end
    // second reset, power-on values and boot kinds
    i_rst = 1'b1;
    cyc(6);
    i_rst = 1'b0;
    foreach (ROWS[i]) begin
      host.rd_word(ROWS[i].c, rv);
      chk("reset value", 16'h0000, rv);
    end
    host.wr_word(8'haa, 16'h0053);
    psi_n = 1'b0;
    cyc(2);
    chk("count pre boot", 16'h0003, 16'(pc));
    for (int k = 0; k < 2; k++) begin
      boot = 1'b1;
      cyc(1);
      boot = 1'b0;
      cyc(2);
      chk("warm", 16'(k), 16'(warm));
      chk("count psi", k ? 16'h0005 : 16'h0003, 16'(pc));
    end
    psi_n = 1'b1;
    automatic_phase_shedding = 1'b1;
    host.wr_word(8'hab, 16'h0a00);
    cyc(4);
    chk("count shed", 16'h0002, 16'(pc));
    chk("shedding", 16'h0001, 16'(shed));
    fb = 1'b1;
    cyc(1);
    fb = 1'b0;
    chk("uv forced", 16'h0001, 16'(forced));
    cyc(14);
    chk("resume hold", 16'h0001, 16'(forced));
    cyc(12);
    chk("resume end", 16'h0002, 16'(pc));
    host.wr_word(8'hab, 16'h0800);
    shrt = 1'b1;
    cyc(5);
    chk("short off", 16'h0000, 16'(forced));
    host.wr_word(8'hab, 16'h0900);
    cyc(3);
    chk("short on", 16'h0001, 16'(forced));
    shrt = 1'b0;
    host.wr_word(8'hab, 16'h0880);
    cyc(30);
    vly = 1'b1;
    cyc(4);
    chk("valley two", 16'h0000, 16'(forced));
    vly = 1'b0;
    target = 4'h1;
    cyc(4);
    vly = 1'b1;
    cyc(2);
    chk("valley one", 16'h0006, 16'(pc));
    vly = 1'b0;
    automatic_phase_shedding = 1'b0;
    host.wr_word(8'hab, 16'h0005);
    target = 4'h2;
    cyc(3);
    automatic_phase_shedding = 1'b1;
    cyc(100);
    chk("seq hold", 16'h0006, 16'(pc));
    cyc(500);
    chk("seq one", 16'h0005, 16'(pc));
    cyc(2400);
    chk("seq end", 16'h0002, 16'(pc));
    for (int m = 0; m < 4; m++) begin
      host.wr_word(8'had, {4'h0, 2'(m), 10'h002});
      cyc(2);
      chk("modes", {em(2'(m), 1, 0), em(2'(m), 1, 0), em(2'(m), 1, 1), 2'b01},
        {mv, mvo, mi, mt});
      chk("power modes", {3{em(2'(m), 0, 1)}}, {me, mpo, mpi});
    end
    host.sb(8'he0);
    chk("busy", 16'h0001, 16'(busy));
    n = 0;
    while (done !== 1'b1 && n < 80) begin
      cyc(1);
      n++;
    end
    chk("window", 16'h0001, 16'(n >= 40 && n <= 44));
    chk("captured", 16'h0100, rep);
    sample = 16'h0300;
    cyc(60);
    chk("held", 16'h0100, rep);
    n0 = nk;
    host.sb(8'h77);
    cyc(2);
    chk("sb nack", 16'h0001, 16'(nk - n0));
    host.wr_word(8'had, 16'h0402);
    cyc(3);
    chk("rt report", 16'h0300, rep);
    test_done();
  end
endmodule // psrc_top_tb
